// ==== dv/int_line_host.sv ====
`timescale 1ns/100ps
// Host side of the interrupt wire: a pull-up that the device may only pull low.
module int_line_host (
  input  wire logic pinOe,
  input  wire logic pinOut,
  output logic      wireLvl
);
  // The pin counts only while enabled, and then only as a low; the pull-up gives the high.
  // The host never pulls the line itself, so it stays high through power-up.
  assign wireLvl = (pinOe === 1'b1 && pinOut === 1'b0) ? 1'b0 : 1'b1;
endmodule : int_line_host

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import ir_adc_pkg::*;
  logic     clk_sys = 1'b0;
  logic     arst_n = 1'b0;
  byte_type regAddr = 8'h00;
  byte_type regWdata = 8'h00;
  logic     regWr = 1'b0;
  logic     regRd = 1'b0;
  logic     convStart = 1'b0;
  byte_type regRdata, oldRdata, rd;
  logic     convBusy, adcClkEn, rangeHigh, irq, intPinOut, intPinOe, lowPowerEn, intWire;
  logic [2:0] scaleCode;
  logic [2:0] oldScale;
  logic       oldRange;
  int       mismatches = 0;
  int       n_tests = 0;
  int       cycles = 0;
  // Clock at 200 MHz.
  always #2.5 clk_sys = ~clk_sys;
  ir_ambient_adc_param_config i_ir_ambient_adc_param_config (.clk_sys(clk_sys), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .convStart(convStart), .convBusy(convBusy), .adcClkEn(adcClkEn), .scaleCode(scaleCode),
    .rangeHigh(rangeHigh), .irq(irq), .intPinIn(intWire), .intPinOut(intPinOut), .intPinOe(intPinOe),
    .lowPowerEn(lowPowerEn));
  // An older sequencer revision shares the bus so refusals can be seen on its read data.
  ir_ambient_adc_param_config #(.SEQ_REVISION(8'h02)) i_old_rev (.clk_sys(clk_sys), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(oldRdata),
    .convStart(convStart), .convBusy(), .adcClkEn(), .scaleCode(oldScale), .rangeHigh(oldRange), .irq(),
    .intPinIn(1'b1),
    .intPinOut(), .intPinOe(), .lowPowerEn());
  int_line_host i_int_line_host (.pinOe(intPinOe), .pinOut(intPinOut), .wireLvl(intWire));
  task automatic chk(input string what, input byte_type exp, input byte_type got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // A hang counts as a failure and still reaches the report.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic wr(input byte_type a, input byte_type d);
    @(posedge clk_sys);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe is taken.
  task automatic rdb(input byte_type a, output byte_type d);
    @(posedge clk_sys);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rdb
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (adcClkEn !== 1'b1 && n < 3000);
  endtask : wait_pulse
  task automatic t_reset_and_fields();
    rdb(8'h1E, rd); chk("scale reset", 8'h00, rd);
    rdb(8'h1F, rd); chk("options reset", 8'h00, rd);
    chk("low power", 8'h01, {7'h0, lowPowerEn});
    wr(8'h1E, 8'h07); rdb(8'h1E, rd); chk("scale write", 8'h07, rd);
    wr(8'h1F, 8'hFF); rdb(8'h1F, rd); chk("options kept bits", 8'h3F, rd);
    rdb(8'h55, rd); chk("unmapped read", 8'h00, rd);
    rdb(8'h1F, rd);
    chk("old rev options", 8'h00, oldRdata);
    rdb(8'h22, rd);
    chk("block state", 8'h02, rd);
    rdb(8'h1E, rd); #0; chk("old rev scale", 8'h00, oldRdata);
  endtask : t_reset_and_fields
  // Every scale code: interval between converter clocks, exported range and done status.
  task automatic t_codes();
    int n;
    wr(8'h21, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h1E, byte_type'(c));
      rdb(8'h1F, rd);
      wr(8'h1F, (rd & 8'hDF) | byte_type'((c & 1) << 5));
      @(posedge clk_sys); convStart <= 1'b1;
      @(posedge clk_sys); convStart <= 1'b0;
      #1 chk("scale code", byte_type'(c), {5'h0, scaleCode});
      chk("range high", byte_type'(c & 1), {7'h0, rangeHigh});
      chk("old rev conversion", 8'h00, {4'h0, oldRange, oldScale});
      chk("busy at start", 8'h01, {7'h0, convBusy});
      wait_pulse(n);
      wait_pulse(n);
      chk("clock interval", byte_type'((10 << c) & 8'hFF), byte_type'(n & 8'hFF));
      chk("clock interval high", byte_type'((10 << c) >> 8), byte_type'(n >> 8));
      n = 0;
      while (convBusy === 1'b1 && n < 30000) begin
        @(posedge clk_sys);
        #1 n++;
      end
      chk("busy at end", 8'h00, {7'h0, convBusy});
      rdb(8'h20, rd); chk("done status", 8'h01, rd & 8'h01);
      chk("masked irq", 8'h00, {7'h0, irq});
      wr(8'h20, 8'h03);
    end
  endtask : t_codes
  task automatic t_irq();
    int n;
    wr(8'h1E, 8'h00); wr(8'h21, 8'h03);
    @(posedge clk_sys); convStart <= 1'b1;
    @(posedge clk_sys); convStart <= 1'b0;
    @(posedge clk_sys); convStart <= 1'b1;
    @(posedge clk_sys); convStart <= 1'b0;
    n = 0;
    while (intWire !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    rdb(8'h20, rd); chk("refused start", 8'h02, rd);
    chk("pin pulled low", 8'h00, {7'h0, intWire});
    chk("pin enable", 8'h01, {7'h0, intPinOe});
    n = 0;
    while (irq !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("drive only low", 8'h00, {7'h0, intPinOut});
    rdb(8'h20, rd); chk("done then", 8'h03, rd);
    wr(8'h20, 8'h03);
    repeat (3) @(posedge clk_sys);
    #1 chk("irq cleared", 8'h00, {7'h0, irq});
    chk("pin released", 8'h01, {7'h0, intWire});
  endtask : t_irq
  // Reset in mid-run while scale and range hold non-zero values from the sweep.
  task automatic t_mid_reset();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rdb(8'h1E, rd);
    chk("scale after reset", 8'h00, rd);
    rdb(8'h1F, rd);
    chk("options after reset", 8'h00, rd);
    chk("range after reset", 8'h00, {7'h0, rangeHigh});
  endtask : t_mid_reset
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset_and_fields();
    t_codes();
    t_mid_reset();
    t_irq();
    complete_run();
  end
endmodule : testbench

// ==== src/ir_adc_pkg.sv ====
package ir_adc_pkg;
  // Conversion sequencer states, Gray coded along idle, integrate, done.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INTEG = 2'b01,
    ST_DONE  = 2'b11
  } conv_state_type;
  typedef logic [7:0] byte_type;
endpackage : ir_adc_pkg

// ==== src/ir_adc_regs.svh ====
`ifndef IR_ADC_REGS_SVH
`define IR_ADC_REGS_SVH
// What this block does
// - IR ambient integration time is stretched by two to the three-bit scale code.
// - Bit 5 of conversion options selects high signal range, gain divided by 14.5.
// - Both IR parameters only work on sequencer revision A03 or newer.
// - Interrupt pin is open drain and only ever pulls low.
// - Both IR parameters reset to all zeros: unity scale, normal range.

// Register offsets.
`define OFS_IR_SCALE    8'h1E
`define OFS_IR_OPTIONS  8'h1F
`define OFS_IRQ_STATUS  8'h20
`define OFS_IRQ_MASK    8'h21
`define OFS_BLOCK_STATE 8'h22

// Field positions and widths.
`define SCALE_MSB       2
`define OPT_MSB         5
`define OPT_SPAN_BIT    5
`define EVT_DONE        0
`define EVT_REJECT      1
`define EVT_COUNT       2

// Reset values.
`define RST_IR_SCALE    3'h0
`define RST_IR_OPTIONS  6'h00

// Revision gate; parameters exist from this sequencer revision on.
`define REV_A03         8'h03

// Timing: one converter clock is 50 ns at the 5 ns system clock.
`define SYS_CLK_NS      5
`define ADC_CLK_NS      50
`define ADC_DIV_CYC     (`ADC_CLK_NS / `SYS_CLK_NS)
`define INTEG_ADC_CLKS  16
`endif

// ==== src/ir_ambient_adc_param_config.sv ====
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "ir_adc_regs.svh"

module ir_ambient_adc_param_config #(
  parameter logic [7:0] SEQ_REVISION = 8'h03
) (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire ir_adc_pkg::byte_type regAddr,
  input  wire ir_adc_pkg::byte_type regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output ir_adc_pkg::byte_type     regRdata,
  input  wire logic                convStart,
  output logic                     convBusy,
  output logic                     adcClkEn,
  output logic [2:0]               scaleCode,
  output logic                     rangeHigh,
  output logic                     irq,
  input  wire logic                intPinIn,
  output logic                     intPinOut,
  output logic                     intPinOe,
  output logic                     lowPowerEn
);
  import ir_adc_pkg::*;

  // Address match, shared by the write and read decoders.
  function automatic logic hit(input byte_type a, input byte_type ofs);
    hit = (a == ofs);
  endfunction : hit

  localparam logic paramsOn = (SEQ_REVISION >= `REV_A03);
  localparam logic [3:0] divLast = 4'(`ADC_DIV_CYC - 1);
  localparam logic [4:0] integLast = 5'(`INTEG_ADC_CLKS - 1);

  conv_state_type state_q;
  logic [`SCALE_MSB:0]   scale_q;
  logic [`OPT_MSB:0]     opts_q;
  logic [`EVT_COUNT-1:0] stat_q;
  logic [`EVT_COUNT-1:0] mask_q;
  logic [`EVT_COUNT-1:0] evtSet;
  logic [3:0]            div_q;
  logic [6:0]            stretch_q;
  logic [4:0]            integ_q;
  logic                  baseTick;
  logic                  stretchTick;
  logic                  strapDone_q;
  byte_type              rdata_q;
  logic                  irq_q;
  logic                  oe_q;
  logic                  busy_q;
  logic                  clkEn_q;
  logic [2:0]            curScale_q;
  logic                  curRange_q;
  logic                  lowPow_q;
  logic                  pinOut_q;

  // Parameter registers; on old revisions they do not exist and stay zero.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scale_q <= `RST_IR_SCALE;
      opts_q  <= `RST_IR_OPTIONS;
    end else if (regWr && paramsOn) begin
      if (hit(regAddr, `OFS_IR_SCALE)) begin
        scale_q <= regWdata[`SCALE_MSB:0];
      end else if (hit(regAddr, `OFS_IR_OPTIONS)) begin
        // Bits 5 to 0 are stored as written so a read-modify-write round trips.
        opts_q <= regWdata[`OPT_MSB:0];
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= '0;
    end else if (regWr && hit(regAddr, `OFS_IRQ_MASK)) begin
      mask_q <= regWdata[`EVT_COUNT-1:0];
    end
  end

  // Events: conversion finished, and a start refused because one was running.
  assign evtSet[`EVT_DONE]   = (state_q == ST_DONE);
  assign evtSet[`EVT_REJECT] = convStart && (state_q != ST_IDLE);

  // Sticky status bits, write one to clear; a new event beats a clear.
  generate
    for (genvar i = 0; i < `EVT_COUNT; i++) begin : g_stat
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          stat_q[i] <= 1'b0;
        end else if (evtSet[i]) begin
          stat_q[i] <= 1'b1;
        end else if (regWr && hit(regAddr, `OFS_IRQ_STATUS) && regWdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read port, data valid in the cycle after the strobe only.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (!regRd) begin
      rdata_q <= '0;
    end else if (hit(regAddr, `OFS_IR_SCALE)) begin
      rdata_q <= paramsOn ? {5'h0, scale_q} : 8'h00;
    end else if (hit(regAddr, `OFS_IR_OPTIONS)) begin
      rdata_q <= paramsOn ? {2'h0, opts_q} : 8'h00;
    end else if (hit(regAddr, `OFS_IRQ_STATUS)) begin
      rdata_q <= {6'h00, stat_q};
    end else if (hit(regAddr, `OFS_IRQ_MASK)) begin
      rdata_q <= {6'h00, mask_q};
    end else if (hit(regAddr, `OFS_BLOCK_STATE)) begin
      rdata_q <= {6'h00, lowPow_q, busy_q};
    end else begin
      rdata_q <= '0;
    end
  end

  // Interrupt level and the open-drain pin; the pin is only ever pulled low.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_q    <= 1'b0;
      oe_q     <= 1'b0;
      pinOut_q <= 1'b0;
    end else begin
      irq_q    <= |(stat_q & mask_q);
      oe_q     <= |(stat_q & mask_q);
      pinOut_q <= 1'b0;
    end
  end

  // The pin level is caught once after reset release, before we can drive it.
  // A low line here means the host broke power-up rules, so low power stays off.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strapDone_q <= 1'b0;
      lowPow_q    <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      lowPow_q    <= intPinIn;
    end
  end

  // Base converter clock enable, one pulse per 50 ns while integrating.
  assign baseTick = (div_q == divLast);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else if (state_q != ST_INTEG || baseTick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Stretch divider: one converter clock every two to the scale base ticks.
  assign stretchTick = baseTick && (stretch_q == 7'((8'h01 << curScale_q) - 8'h01));
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stretch_q <= '0;
    end else if (state_q != ST_INTEG || stretchTick) begin
      stretch_q <= '0;
    end else if (baseTick) begin
      stretch_q <= stretch_q + 7'h01;
    end
  end

  // Conversion sequencer. Settings are latched at start, so a later write
  // only affects the next conversion and never tears one in progress.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      integ_q    <= '0;
      curScale_q <= '0;
      curRange_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (convStart) begin
            state_q    <= ST_INTEG;
            integ_q    <= '0;
            curScale_q <= paramsOn ? scale_q : 3'h0;
            curRange_q <= paramsOn ? opts_q[`OPT_SPAN_BIT] : 1'b0;
          end
        end
        ST_INTEG: begin
          if (stretchTick) begin
            if (integ_q == integLast) begin
              state_q <= ST_DONE;
            end else begin
              integ_q <= integ_q + 5'h01;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered converter-side outputs.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q  <= 1'b0;
      clkEn_q <= 1'b0;
    end else begin
      busy_q  <= (state_q == ST_IDLE) ? convStart : (state_q == ST_INTEG && !(stretchTick && integ_q == integLast));
      clkEn_q <= stretchTick;
    end
  end

  assign regRdata   = rdata_q;
  assign convBusy   = busy_q;
  assign adcClkEn   = clkEn_q;
  assign scaleCode  = curScale_q;
  assign rangeHigh  = curRange_q;
  assign irq        = irq_q;
  assign intPinOut  = pinOut_q;
  assign intPinOe   = oe_q;
  assign lowPowerEn = lowPow_q;

  // Helper: cycles since the last converter clock in this conversion.
  logic [15:0] gap_q;
  logic        first_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_q   <= '0;
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
      gap_q   <= (state_q != ST_INTEG || stretchTick) ? 16'h0000 : gap_q + 16'h0001;
    end
  end

  sequence s_start;
    state_q == ST_IDLE && convStart;
  endsequence

  property p_scale_latch;
    @(posedge clk_sys) disable iff (!arst_n)
    s_start |=> curScale_q == (paramsOn ? $past(scale_q) : 3'h0);
  endproperty
  a_scale_latch: assert property (p_scale_latch) else $error("Scale not latched at start.");

  property p_stretch_period;
    @(posedge clk_sys) disable iff (!arst_n)
    stretchTick |-> gap_q == 16'((16'(`ADC_DIV_CYC) << curScale_q) - 16'h0001);
  endproperty
  a_stretch_period: assert property (p_stretch_period) else $error("Converter clock period wrong.");

  property p_range_latch;
    @(posedge clk_sys) disable iff (!arst_n)
    s_start ##1 1'b1 |-> rangeHigh == (paramsOn && $past(opts_q[`OPT_SPAN_BIT]));
  endproperty
  a_range_latch: assert property (p_range_latch) else $error("Range select not applied.");

  property p_rev_gate;
    @(posedge clk_sys) disable iff (!arst_n)
    (regRd && !paramsOn && (regAddr == `OFS_IR_SCALE || regAddr == `OFS_IR_OPTIONS)) |=> regRdata == 8'h00;
  endproperty
  a_rev_gate: assert property (p_rev_gate) else $error("Parameter visible on old revision.");

  property p_open_drain;
    @(posedge clk_sys) disable iff (!arst_n)
    (|(stat_q & mask_q)) |=> intPinOe && !intPinOut && irq;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Interrupt pin not pulled low.");

  property p_reset_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    first_q |-> scale_q == 3'h0 && opts_q == 6'h00 && !rangeHigh;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("Parameters not zero after reset.");

endmodule : ir_ambient_adc_param_config
